/* shared/fdr_pkg.sv */
// constants and types shared by the fault and disturbance recorder
package fdr_pkg;
	// ------------------------------------------------------------
	// time base
	// ------------------------------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int SYS_HZ = 50;
	localparam int SAMPLES_PER_CYCLE = 32;
	localparam int SAMPLES_PER_S = SAMPLES_PER_CYCLE * SYS_HZ;
	localparam int SAMPLE_DIV_DEF = CLK_HZ / SAMPLES_PER_S;
	localparam int MS_PER_S = 1000;
	localparam int MS_DIV_DEF = CLK_HZ / MS_PER_S;
	localparam int DIVW = 17;
	// ------------------------------------------------------------
	// disturbance recorder
	// ------------------------------------------------------------
	localparam int SW = 18;
	localparam int REC_LIMIT_S = 15;
	localparam int STORE_S = 120;
	localparam logic [SW-1:0] REC_LIMIT_SMP = SW'(REC_LIMIT_S * SAMPLES_PER_S);
	localparam logic [SW-1:0] STORE_SMP = SW'(STORE_S * SAMPLES_PER_S);
	localparam logic [SW-1:0] STORE_LAST = SW'(STORE_S * SAMPLES_PER_S - 1);
	localparam int TRIG_N = 8;
	localparam int DR_SLOTS = 16;
	localparam int DRIW = 4;
	localparam int CW = 5;
	localparam int PW = 7;
	localparam logic [PW-1:0] PCT_FULL = 7'h64;
	// ------------------------------------------------------------
	// fault recorder
	// ------------------------------------------------------------
	localparam int FR_MODS = 8;
	localparam int MODW = 3;
	localparam int FR_DEPTH = 20;
	localparam int FR_IW = 5;
	localparam logic [FR_IW-1:0] FR_LAST = 5'h13;
	localparam logic [FR_IW-1:0] FR_FULL = 5'h14;
	localparam int TW = 16;
	localparam int MW = 16;
	localparam logic [TW-1:0] T_MAX = 16'hFFFF;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DR_IDLE = 3'h0,
		DR_EVENT = 3'h1,
		DR_POST = 3'h2,
		DR_EVICT = 3'h3,
		DR_LOCK = 3'h4
	} fdr_dr_state_t;
	typedef enum logic [0:0] {
		FR_IDLE = 1'h0,
		FR_ACTIVE = 1'h1
	} fdr_fr_state_t;
	typedef struct packed {
		logic [TRIG_N-1:0] start_sel;
		logic [SW-1:0] record_limit;
		logic [PW-1:0] pre_pct;
		logic [PW-1:0] post_pct;
		logic overwrite;
	} fdr_dr_cfg_t;
	typedef struct packed {
		logic alarms_mode;
		logic [TW-1:0] meas_delay;
	} fdr_fr_cfg_t;
	typedef struct packed {
		logic [TW-1:0] dur;
		logic [TW-1:0] ttt;
		logic ttt_vld;
		logic tripped;
		logic [MW-1:0] meas;
		logic [MODW-1:0] pick_mod;
		logic [MODW-1:0] trip_mod;
	} fdr_rec_t;
endpackage

/* hdl/fdr_top.sv */
// fault and disturbance record management
// Functional notes
// - disturbance samples are taken 32 times per power-system cycle.
// - eight selectable start signals are OR-ed into the recorder trigger.
// - after a record, triggers wait until its causing start signals drop.
// - total disturbance storage is 120 s; record count depends on length, up to 16 directory slots.
// - one record is at most 15 s including pre and post portions.
// - pre and post durations are percentages of the record limit.
// - every record holds exactly the configured pre-trigger portion.
// - event portion is min of trigger duration and limit minus pre.
// - post portion is min of post setting and remaining length; may be zero.
// - recording always stops when the record limit has elapsed.
// - full storage either overwrites oldest records or refuses new ones.
// - manual trigger starts a recording like a start signal.
// - delete removes the selected record or all records.
// - fault record starts on rising edge of general pickup.
// - measurements captured at trip, optionally after a delay.
// - alarms mode stores pickups without trip; trips-only mode discards them.
// - notification raised when a record is stored at fall of general pickup; cleared by acknowledge.
// - time-to-trip reported only when pickup and trip modules match.
// - fault duration runs from rise to fall of general pickup.
// - general trip is the OR of all module trips.
// - twenty fault records, oldest overwritten; newest goes to non-volatile store.
// - each fault record keeps a tripped flag.
`timescale 1ns/1ps
module fdr_top #(
	parameter int SAMPLE_DIV = fdr_pkg::SAMPLE_DIV_DEF,
	parameter int MS_DIV = fdr_pkg::MS_DIV_DEF
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire fdr_pkg::fdr_dr_cfg_t dr_cfg_i,
	input wire logic [fdr_pkg::TRIG_N-1:0] dr_start_i,
	input wire logic man_trig_i,
	input wire logic del_req_i,
	input wire logic del_all_i,
	input wire logic [fdr_pkg::DRIW-1:0] del_slot_i,
	input wire fdr_pkg::fdr_fr_cfg_t fr_cfg_i,
	input wire logic [fdr_pkg::FR_MODS-1:0] pickup_i,
	input wire logic [fdr_pkg::FR_MODS-1:0] trip_i,
	input wire logic [fdr_pkg::MW-1:0] meas_i,
	input wire logic ack_i,
	output logic dr_wr_o,
	output logic [fdr_pkg::SW-1:0] dr_addr_o,
	output logic dr_active_o,
	output logic [fdr_pkg::CW-1:0] dr_count_o,
	output logic [fdr_pkg::SW-1:0] dr_used_o,
	output logic gen_pickup_o,
	output logic gen_trip_o,
	output logic fr_notify_o,
	output fdr_pkg::fdr_rec_t fr_newest_o,
	output logic [fdr_pkg::FR_IW-1:0] fr_count_o,
	output logic [fdr_pkg::FR_DEPTH-1:0] fr_trip_flags_o,
	output logic fr_nv_wr_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		fdr_pkg::fdr_dr_state_t dr_st;
		logic [fdr_pkg::DIVW-1:0] smp_div;
		logic [fdr_pkg::DIVW-1:0] ms_div;
		logic [fdr_pkg::SW-1:0] wr_ptr;
		logic [fdr_pkg::SW-1:0] fill;
		logic [fdr_pkg::SW-1:0] elapsed;
		logic [fdr_pkg::SW-1:0] post_cnt;
		logic [fdr_pkg::TRIG_N-1:0] mask;
		logic pend;
		logic dr_wr;
		logic active;
		logic [fdr_pkg::SW-1:0] used;
		logic [fdr_pkg::DR_SLOTS-1:0] dir_vld;
		logic [fdr_pkg::DR_SLOTS-1:0][fdr_pkg::SW-1:0] dir_len;
		logic [fdr_pkg::DRIW-1:0] head;
		logic [fdr_pkg::DRIW-1:0] tail;
		logic [fdr_pkg::CW-1:0] dr_cnt;
		fdr_pkg::fdr_fr_state_t fr_st;
		logic gp;
		logic gt;
		fdr_pkg::fdr_rec_t cur;
		logic meas_pend;
		logic [fdr_pkg::TW-1:0] mdly;
		fdr_pkg::fdr_rec_t [fdr_pkg::FR_DEPTH-1:0] recs;
		logic [fdr_pkg::FR_IW-1:0] fr_wr;
		logic [fdr_pkg::FR_IW-1:0] fr_cnt;
		logic [fdr_pkg::FR_DEPTH-1:0] trip_flags;
		fdr_pkg::fdr_rec_t newest;
		logic notify;
		logic nv_wr;
	} fdr_state_t;

	localparam logic [fdr_pkg::DIVW-1:0] SMP_LAST = fdr_pkg::DIVW'(SAMPLE_DIV - 1);
	localparam logic [fdr_pkg::DIVW-1:0] MS_LAST = fdr_pkg::DIVW'(MS_DIV - 1);

	fdr_state_t q;
	fdr_state_t d;
	logic smp_tick;
	logic ms_tick;
	logic trig;
	logic gp;
	logic gt;
	logic fits;
	logic store;
	logic [fdr_pkg::SW-1:0] lim;
	logic [fdr_pkg::SW-1:0] pre;
	logic [fdr_pkg::SW-1:0] post;
	logic [fdr_pkg::SW:0] need;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [fdr_pkg::SW-1:0] pct_of(input logic [fdr_pkg::PW-1:0] pct,
			input logic [fdr_pkg::SW-1:0] limit);
		logic [fdr_pkg::PW-1:0] pc;
		logic [fdr_pkg::SW+fdr_pkg::PW-1:0] prod;
		pc = (pct > fdr_pkg::PCT_FULL) ? fdr_pkg::PCT_FULL : pct;
		prod = limit * pc;
		return fdr_pkg::SW'(prod / fdr_pkg::PCT_FULL);
	endfunction

	function automatic logic [fdr_pkg::MODW-1:0] first_mod(input logic [fdr_pkg::FR_MODS-1:0] v);
		logic [fdr_pkg::MODW-1:0] idx;
		idx = '0;
		for (int i = fdr_pkg::FR_MODS - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = fdr_pkg::MODW'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [fdr_pkg::TW-1:0] sat_inc(input logic [fdr_pkg::TW-1:0] v);
		return (v == fdr_pkg::T_MAX) ? v : v + 16'h0001;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.dr_wr = 1'h0;
		d.nv_wr = 1'h0;
		store = 1'h0;
		smp_tick = (q.smp_div == SMP_LAST);
		ms_tick = (q.ms_div == MS_LAST);
		d.smp_div = smp_tick ? '0 : q.smp_div + 17'h00001;
		d.ms_div = ms_tick ? '0 : q.ms_div + 17'h00001;
		trig = (|(dr_start_i & dr_cfg_i.start_sel)) | man_trig_i;
		// zero or oversize limit falls back to the ceiling
		lim = (dr_cfg_i.record_limit == '0 || dr_cfg_i.record_limit > fdr_pkg::REC_LIMIT_SMP) ?
			fdr_pkg::REC_LIMIT_SMP : dr_cfg_i.record_limit;
		pre = pct_of(dr_cfg_i.pre_pct, lim);
		post = pct_of(dr_cfg_i.post_pct, lim);
		need = {1'h0, q.used} + {1'h0, lim};
		fits = (need <= {1'h0, fdr_pkg::STORE_SMP}) && !q.dir_vld[q.tail];

		// continuous sample stream keeps the pre-trigger history alive
		if (smp_tick) begin
			d.dr_wr = 1'h1;
			d.wr_ptr = (q.wr_ptr == fdr_pkg::STORE_LAST) ? '0 : q.wr_ptr + 18'h00001;
			if (q.fill < fdr_pkg::REC_LIMIT_SMP) begin
				d.fill = q.fill + 18'h00001;
			end
		end

		case (q.dr_st)
			fdr_pkg::DR_IDLE: begin
				// a trigger is held off until a full pre-trigger history exists
				if ((trig || q.pend) && q.fill >= pre) begin
					if (fits) begin
						d.dr_st = fdr_pkg::DR_EVENT;
						d.elapsed = pre;
						d.post_cnt = '0;
						d.mask = dr_start_i & dr_cfg_i.start_sel;
						d.pend = 1'h0;
					end else if (dr_cfg_i.overwrite && q.dr_cnt != '0) begin
						d.dr_st = fdr_pkg::DR_EVICT;
						d.pend = 1'h1;
					end else begin
						d.pend = 1'h0;
					end
				end
			end
			fdr_pkg::DR_EVICT: begin
				if (q.dir_vld[q.head]) begin
					d.dir_vld[q.head] = 1'h0;
					d.used = q.used - q.dir_len[q.head];
					d.dr_cnt = q.dr_cnt - 5'h01;
				end
				d.head = q.head + 4'h1;
				d.dr_st = fdr_pkg::DR_IDLE;
			end
			fdr_pkg::DR_EVENT: begin
				d.mask = q.mask | (dr_start_i & dr_cfg_i.start_sel);
				if (smp_tick) begin
					d.elapsed = q.elapsed + 18'h00001;
				end
				if (d.elapsed >= lim) begin
					store = 1'h1;
				end else if (!trig) begin
					if (post == '0) begin
						store = 1'h1;
					end else begin
						d.dr_st = fdr_pkg::DR_POST;
					end
				end
			end
			fdr_pkg::DR_POST: begin
				if (smp_tick) begin
					d.elapsed = q.elapsed + 18'h00001;
					d.post_cnt = q.post_cnt + 18'h00001;
				end
				if (d.elapsed >= lim || d.post_cnt >= post) begin
					store = 1'h1;
				end
			end
			fdr_pkg::DR_LOCK: begin
				if ((dr_start_i & q.mask) == '0) begin
					d.dr_st = fdr_pkg::DR_IDLE;
				end
			end
			default: begin
				d.dr_st = fdr_pkg::DR_IDLE;
			end
		endcase

		if (store) begin
			d.dir_vld[q.tail] = 1'h1;
			d.dir_len[q.tail] = d.elapsed;
			d.used = q.used + d.elapsed;
			d.dr_cnt = q.dr_cnt + 5'h01;
			d.tail = q.tail + 4'h1;
			d.dr_st = fdr_pkg::DR_LOCK;
		end

		// deletes are only taken while no recording is in progress
		if (del_req_i && (q.dr_st == fdr_pkg::DR_IDLE || q.dr_st == fdr_pkg::DR_LOCK)) begin
			if (del_all_i) begin
				d.dir_vld = '0;
				d.used = '0;
				d.dr_cnt = '0;
				d.head = '0;
				d.tail = '0;
			end else if (q.dir_vld[del_slot_i]) begin
				d.dir_vld[del_slot_i] = 1'h0;
				d.used = q.used - q.dir_len[del_slot_i];
				d.dr_cnt = q.dr_cnt - 5'h01;
			end
		end
		d.active = (d.dr_st == fdr_pkg::DR_EVENT) || (d.dr_st == fdr_pkg::DR_POST);

		// fault recorder
		gp = |pickup_i;
		gt = |trip_i;
		d.gp = gp;
		d.gt = gt;
		if (ack_i) begin
			d.notify = 1'h0;
		end
		case (q.fr_st)
			fdr_pkg::FR_IDLE: begin
				if (gp && !q.gp) begin
					d.fr_st = fdr_pkg::FR_ACTIVE;
					d.cur = '0;
					d.cur.pick_mod = first_mod(pickup_i);
					d.meas_pend = 1'h0;
				end
			end
			fdr_pkg::FR_ACTIVE: begin
				if (ms_tick) begin
					d.cur.dur = sat_inc(q.cur.dur);
					if (!q.cur.tripped) begin
						d.cur.ttt = sat_inc(q.cur.ttt);
					end
				end
				if (gt && !q.cur.tripped) begin
					d.cur.tripped = 1'h1;
					d.cur.trip_mod = first_mod(trip_i);
					d.cur.ttt_vld = (first_mod(trip_i) == q.cur.pick_mod);
					if (fr_cfg_i.meas_delay == '0) begin
						d.cur.meas = meas_i;
					end else begin
						d.meas_pend = 1'h1;
						d.mdly = fr_cfg_i.meas_delay;
					end
				end else if (q.meas_pend && ms_tick) begin
					d.mdly = q.mdly - 16'h0001;
					if (q.mdly == 16'h0001) begin
						d.cur.meas = meas_i;
						d.meas_pend = 1'h0;
					end
				end
				if (!gp) begin
					// a fault ending before the delay runs out keeps its last sample
					if (d.meas_pend) begin
						d.cur.meas = meas_i;
						d.meas_pend = 1'h0;
					end
					if (!d.cur.ttt_vld) begin
						d.cur.ttt = '0;
					end
					d.fr_st = fdr_pkg::FR_IDLE;
					if (d.cur.tripped || fr_cfg_i.alarms_mode) begin
						d.recs[q.fr_wr] = d.cur;
						d.trip_flags[q.fr_wr] = d.cur.tripped;
						d.fr_wr = (q.fr_wr == fdr_pkg::FR_LAST) ? '0 : q.fr_wr + 5'h01;
						d.fr_cnt = (q.fr_cnt == fdr_pkg::FR_FULL) ? q.fr_cnt : q.fr_cnt + 5'h01;
						d.newest = d.cur;
						d.nv_wr = 1'h1;
						d.notify = 1'h1;
					end
				end
			end
			default: begin
				d.fr_st = fdr_pkg::FR_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign dr_wr_o = q.dr_wr;
	assign dr_addr_o = q.wr_ptr;
	assign dr_active_o = q.active;
	assign dr_count_o = q.dr_cnt;
	assign dr_used_o = q.used;
	assign gen_pickup_o = q.gp;
	assign gen_trip_o = q.gt;
	assign fr_notify_o = q.notify;
	assign fr_newest_o = q.newest;
	assign fr_count_o = q.fr_cnt;
	assign fr_trip_flags_o = q.trip_flags;
	assign fr_nv_wr_o = q.nv_wr;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_smp_rate;
		@(posedge mclk_i) disable iff (!resetn_i)
		smp_tick |=> dr_wr_o ##1 !dr_wr_o;
	endproperty
	a_smp_rate: assert property (p_smp_rate) else $error("sample strobe missing");

	property p_trig_start;
		@(posedge mclk_i) disable iff (!resetn_i)
		(q.dr_st == fdr_pkg::DR_IDLE && trig && q.fill >= pre && fits && !del_req_i) |=>
			(q.dr_st == fdr_pkg::DR_EVENT && q.elapsed == $past(pre));
	endproperty
	a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

	property p_lockout;
		@(posedge mclk_i) disable iff (!resetn_i)
		(q.dr_st == fdr_pkg::DR_LOCK && (dr_start_i & q.mask) != '0) |=>
			q.dr_st == fdr_pkg::DR_LOCK;
	endproperty
	a_lockout: assert property (p_lockout) else $error("lockout released early");

	property p_capacity;
		@(posedge mclk_i) disable iff (!resetn_i)
		q.used <= fdr_pkg::STORE_SMP;
	endproperty
	a_capacity: assert property (p_capacity) else $error("storage overrun");

	property p_limit;
		@(posedge mclk_i) disable iff (!resetn_i)
		(q.dr_st == fdr_pkg::DR_EVENT || q.dr_st == fdr_pkg::DR_POST) |-> q.elapsed < lim;
	endproperty
	a_limit: assert property (p_limit) else $error("record exceeded limit");

	property p_event_end;
		@(posedge mclk_i) disable iff (!resetn_i)
		(q.dr_st == fdr_pkg::DR_EVENT && !trig && post != '0 && d.elapsed < lim) |=>
			q.dr_st == fdr_pkg::DR_POST;
	endproperty
	a_event_end: assert property (p_event_end) else $error("event did not end");

	property p_refuse;
		@(posedge mclk_i) disable iff (!resetn_i)
		(q.dr_st == fdr_pkg::DR_IDLE && !fits && !dr_cfg_i.overwrite) |=>
			q.dr_st != fdr_pkg::DR_EVENT;
	endproperty
	a_refuse: assert property (p_refuse) else $error("full memory accepted record");

	property p_fr_start;
		@(posedge mclk_i) disable iff (!resetn_i)
		(q.fr_st == fdr_pkg::FR_IDLE && gp && !q.gp) |=>
			(q.fr_st == fdr_pkg::FR_ACTIVE && q.cur.dur == '0);
	endproperty
	a_fr_start: assert property (p_fr_start) else $error("fault record not started");

	property p_discard;
		@(posedge mclk_i) disable iff (!resetn_i)
		(q.fr_st == fdr_pkg::FR_ACTIVE && !gp && !gt && !q.cur.tripped &&
			!fr_cfg_i.alarms_mode) |=>
			(fr_count_o == $past(fr_count_o) && !fr_nv_wr_o);
	endproperty
	a_discard: assert property (p_discard) else $error("untripped fault stored");

	property p_ack;
		@(posedge mclk_i) disable iff (!resetn_i)
		(ack_i && !d.nv_wr) |=> !fr_notify_o;
	endproperty
	a_ack: assert property (p_ack) else $error("notification not cleared");

	property p_notify;
		@(posedge mclk_i) disable iff (!resetn_i)
		fr_nv_wr_o |-> (fr_notify_o && !gen_pickup_o);
	endproperty
	a_notify: assert property (p_notify) else $error("store without notification");
endmodule // fdr_top

/* tb/fdr_prot_model.sv */
// behavioural protection modules issuing pickups, trips and measurements
`timescale 1ns/1ps
module fdr_prot_model (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [7:0] pick_req_i,
	input wire logic [7:0] trip_req_i,
	input wire logic [15:0] meas_req_i,
	output logic [7:0] pickup_o,
	output logic [7:0] trip_o,
	output logic [15:0] meas_o
);
	// ------------------------------------------------------------
	// outputs follow requests one edge late, like a relay stage
	// ------------------------------------------------------------
	initial begin
		pickup_o = 8'h00;
		trip_o = 8'h00;
		meas_o = 16'h0000;
	end
	// requests are read at the edge, before the bench moves them, and shown 1 ns later
	always @(posedge mclk_i) begin
		pickup_o <= #1 (resetn_i ? pick_req_i : 8'h00);
		trip_o <= #1 (resetn_i ? trip_req_i : 8'h00);
		meas_o <= #1 meas_req_i;
	end
endmodule // fdr_prot_model

/* tb/fault_disturbance_recorder_test.sv */
// self-checking bench for the fault and disturbance recorder
`timescale 1ns/1ps
module fault_disturbance_recorder_test;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	fdr_pkg::fdr_dr_cfg_t dr_cfg = '{8'h04, 18'h00064, 7'h0A, 7'h14, 1'b0};
	fdr_pkg::fdr_fr_cfg_t fr_cfg = '{1'b1, 16'h0000};
	logic [7:0] dr_start = 8'h00;
	logic man_trig = 1'b0;
	logic del_req = 1'b0;
	logic del_all = 1'b0;
	logic [3:0] del_slot = 4'h0;
	logic [7:0] pick_req = 8'h00;
	logic [7:0] trip_req = 8'h00;
	logic [15:0] meas_req = 16'h0000;
	logic ack = 1'b0;
	logic [7:0] pickup;
	logic [7:0] trip;
	logic [15:0] meas;
	logic dr_wr, dr_active, gp, gt, notify, nvwr;
	logic [17:0] dr_addr, dr_used;
	logic [17:0] a0;
	logic [4:0] dr_count, fr_count;
	logic [19:0] flags;
	fdr_pkg::fdr_rec_t newest;
	int fail_count = 0;
	int n_compared = 0;
	int n;
	int cnt;
	typedef struct {logic [7:0] p; logic [7:0] t; logic gp; logic gt;} fdr_row_t;
	fdr_row_t rows [4] = '{'{8'h00, 8'h00, 1'b0, 1'b0}, '{8'h80, 8'h00, 1'b1, 1'b0},
		'{8'h01, 8'h40, 1'b1, 1'b1}, '{8'h00, 8'h10, 1'b0, 1'b1}};

	always #4 mclk_i = ~mclk_i;

	fdr_prot_model i_prot (.mclk_i(mclk_i), .resetn_i(resetn_i), .pick_req_i(pick_req),
		.trip_req_i(trip_req), .meas_req_i(meas_req), .pickup_o(pickup), .trip_o(trip),
		.meas_o(meas));

	// short dividers keep the run small
	fdr_top #(.SAMPLE_DIV(4), .MS_DIV(8)) i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.dr_cfg_i(dr_cfg), .dr_start_i(dr_start), .man_trig_i(man_trig), .del_req_i(del_req),
		.del_all_i(del_all), .del_slot_i(del_slot), .fr_cfg_i(fr_cfg), .pickup_i(pickup),
		.trip_i(trip), .meas_i(meas), .ack_i(ack), .dr_wr_o(dr_wr), .dr_addr_o(dr_addr),
		.dr_active_o(dr_active), .dr_count_o(dr_count), .dr_used_o(dr_used),
		.gen_pickup_o(gp), .gen_trip_o(gt), .fr_notify_o(notify), .fr_newest_o(newest),
		.fr_count_o(fr_count), .fr_trip_flags_o(flags), .fr_nv_wr_o(nvwr));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	task automatic wait_act(input logic lvl, input int k);
		n = 0;
		while (dr_active !== lvl && n < k) begin
			tick(1);
			n++;
		end
	endtask
	task automatic wait_nv(input int k);
		n = 0;
		while (nvwr !== 1'b1 && n < k) begin
			tick(1);
			n++;
		end
	endtask
	task automatic fault(input logic [7:0] p, input logic [7:0] t, input int td, input int h);
		pick_req = p;
		tick(td);
		trip_req = t;
		tick(h);
		pick_req = 8'h00;
		trip_req = 8'h00;
	endtask
	task automatic pulse(input int which, input logic all, input logic [3:0] slot);
		del_all = all;
		del_slot = slot;
		if (which == 0)
			del_req = 1'b1;
		else
			man_trig = 1'b1;
		tick(1);
		del_req = 1'b0;
		man_trig = 1'b0;
		tick(3);
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog at 10000 cycles, well beyond the expected run of under two thousand cycles
	initial begin
		#80000;
		fail_count++;
		final_report;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		tick(6);
		resetn_i = 1'b1;
		tick(2);
		for (int i = 0; i < 4; i++) begin
			pick_req = rows[i].p;
			trip_req = rows[i].t;
			tick(3);
			chk(gp, rows[i].gp);
			chk(gt, rows[i].gt);
		end
		pick_req = 8'h00;
		trip_req = 8'h00;
		tick(3);
		$display("table done");
		resetn_i = 1'b0;
		tick(2);
		chk({fr_count, dr_count, notify, gp, dr_active}, 32'h0);
		resetn_i = 1'b1;
		tick(2);
		$display("reset done");
		// trip after 5 ms, measurement moves inside the 2 ms delay
		fr_cfg.meas_delay = 16'h0002;
		meas_req = 16'h1234;
		pick_req = 8'h04;
		tick(40);
		trip_req = 8'h04;
		tick(4);
		meas_req = 16'hABCD;
		tick(76);
		pick_req = 8'h00;
		trip_req = 8'h00;
		wait_nv(10);
		chk(nvwr, 1'b1);
		chk(notify, 1'b1);
		chk(fr_count, 5'h01);
		chk(newest.tripped, 1'b1);
		chk(flags[0], 1'b1);
		chk({newest.ttt_vld, newest.pick_mod, newest.trip_mod}, 7'h52);
		chk(newest.ttt >= 16'h0004 && newest.ttt <= 16'h0006, 1'b1);
		chk(newest.dur >= 16'h000E && newest.dur <= 16'h0010, 1'b1);
		chk(newest.meas, 16'hABCD);
		ack = 1'b1;
		tick(1);
		ack = 1'b0;
		tick(2);
		chk(notify, 1'b0);
		chk(nvwr, 1'b0);
		fault(8'h02, 8'h08, 5, 10);
		wait_nv(10);
		chk({newest.ttt_vld, newest.ttt}, 17'h00000);
		ack = 1'b1;
		tick(1);
		ack = 1'b0;
		fr_cfg.alarms_mode = 1'b0;
		fault(8'h01, 8'h00, 5, 10);
		tick(10);
		chk({fr_count, notify}, 6'h04);
		fr_cfg.alarms_mode = 1'b1;
		fault(8'h01, 8'h00, 5, 10);
		wait_nv(10);
		chk({fr_count, newest.tripped}, 6'h06);
		for (int i = 0; i < 20; i++) begin
			fault(8'h01, 8'h01, 1, 2);
			tick(3);
		end
		chk(fr_count, 5'h14);
		$display("fault tests done");
		// unselected start bit must not trigger
		dr_start = 8'h08;
		tick(20);
		chk(dr_active, 1'b0);
		dr_start = 8'h0C;
		wait_act(1'b1, 5);
		chk(dr_active, 1'b1);
		tick(119);
		dr_start = 8'h00;
		wait_act(1'b0, 200);
		tick(1);
		chk(dr_count, 5'h01);
		chk(dr_used >= 18'h0003A && dr_used <= 18'h0003E, 1'b1);
		pulse(0, 1'b1, 4'h0);
		chk({dr_count, dr_used}, 23'h0);
		// start held past the limit: stop at limit, then lockout
		dr_start = 8'h04;
		wait_act(1'b1, 5);
		cnt = 0;
		a0 = dr_addr;
		for (int i = 0; i < 40; i++) begin
			tick(1);
			if (dr_wr === 1'b1)
				cnt++;
		end
		chk(cnt, 10);
		chk(dr_addr - a0, 18'h0000A);
		wait_act(1'b0, 500);
		tick(1);
		chk(dr_used, 18'h00064);
		tick(200);
		chk(dr_active, 1'b0);
		dr_start = 8'h00;
		tick(2);
		dr_start = 8'h04;
		wait_act(1'b1, 5);
		chk(dr_active, 1'b1);
		dr_start = 8'h00;
		wait_act(1'b0, 200);
		tick(1);
		chk(dr_count, 5'h02);
		pulse(0, 1'b0, 4'h0);
		chk(dr_count, 5'h01);
		pulse(0, 1'b1, 4'h0);
		$display("disturbance tests done");
		// fill every directory slot with short manual records
		dr_cfg.post_pct = 7'h00;
		for (int i = 0; i < 16; i++) begin
			pulse(1, 1'b0, 4'h0);
			wait_act(1'b0, 50);
			tick(6);
		end
		chk(dr_count, 5'h10);
		pulse(1, 1'b0, 4'h0);
		tick(40);
		chk(dr_active, 1'b0);
		dr_cfg.overwrite = 1'b1;
		man_trig = 1'b1;
		wait_act(1'b1, 40);
		man_trig = 1'b0;
		chk(dr_active, 1'b1);
		wait_act(1'b0, 50);
		tick(2);
		chk(dr_count, 5'h10);
		$display("storage tests done");
		final_report;
	end
endmodule // fault_disturbance_recorder_test
